// file: hdl/serd_read_engine.sv
// Read engine of a two-wire serial EEPROM target
`timescale 1ns/1ps
module serd_read_engine (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// Two-wire bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Straps and protect
	input wire logic chip_select_strap_0_i,
	input wire logic chip_select_strap_1_i,
	input wire logic chip_select_strap_2_i,
	input wire logic write_protect_input_i,
	// Status
	output logic busy_o
);
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic scl_q;
	logic sda_q;
	serd_pkg::serd_state_t state;
	serd_pkg::serd_state_t next_state;
	logic [3:0] bit_cnt;
	logic [3:0] next_bit_cnt;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [serd_pkg::ADDR_W-1:0] addr;
	logic [serd_pkg::ADDR_W-1:0] next_addr;
	logic sda_oe;
	logic next_sda_oe;
	logic [7:0] mem [serd_pkg::MEM_DEPTH];
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic [2:0] strap_meta;
	logic [2:0] strap;
	logic skip_fall;
	logic next_skip_fall;
	logic next_busy;
	logic [serd_pkg::MEM_AW-1:0] mem_idx;
	logic [7:0] rd_byte;

	// Two-stage synchronisers for the bus pins and the straps
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			strap_meta <= 3'h0;
			strap <= 3'h0;
		end else begin
			scl_sync <= {scl_sync[0], scl_i};
			sda_sync <= {sda_sync[0], sda_i};
			strap_meta <= {chip_select_strap_2_i, chip_select_strap_1_i, chip_select_strap_0_i};
			strap <= strap_meta;
			scl_q <= scl_sync[1];
			sda_q <= sda_sync[1];
		end
	end

	// Bus events seen on synchronised levels
	assign scl_rise = scl_sync[1] & ~scl_q;
	assign scl_fall = ~scl_sync[1] & scl_q;
	assign start_det = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
	assign stop_det = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
	// Upper address bits beyond the array are ignored
	assign mem_idx = addr[serd_pkg::MEM_AW-1:0];
	assign rd_byte = mem[mem_idx];

	// Array starts erased; read-only engine never writes it
	initial begin
		for (int i = 0; i < serd_pkg::MEM_DEPTH; i++) begin
			mem[i] = serd_pkg::ERASED_BYTE;
		end
	end

	// Protocol next-state logic; write protect plays no part in reads
	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_shreg = shreg;
		next_addr = addr;
		next_sda_oe = sda_oe;
		next_skip_fall = skip_fall;
		if (start_det) begin
			// Start or repeated start resets the byte framing
			next_state = serd_pkg::SERD_SEL;
			next_bit_cnt = 4'h0;
			next_sda_oe = 1'b0;
			next_skip_fall = 1'b1;
		end else if (stop_det) begin
			next_state = serd_pkg::SERD_IDLE;
			next_sda_oe = 1'b0;
			next_skip_fall = 1'b0;
		end else if (state != serd_pkg::SERD_IDLE && scl_rise) begin
			if (state == serd_pkg::SERD_READ) begin
				if (bit_cnt == serd_pkg::ACK_SLOT && sda_q) begin
					// Host left the ninth slot high
					next_state = serd_pkg::SERD_IDLE;
				end
			end else if (bit_cnt < serd_pkg::ACK_SLOT) begin
				next_shreg = {shreg[6:0], sda_q};
			end
		end else if (state != serd_pkg::SERD_IDLE && scl_fall && skip_fall) begin
			// The start's own clock fall frames no bit, so it is not counted
			next_skip_fall = 1'b0;
		end else if (state != serd_pkg::SERD_IDLE && scl_fall) begin
			next_bit_cnt = bit_cnt + 4'h1;
			next_sda_oe = 1'b0;
			case (state)
				serd_pkg::SERD_SEL: begin
					if (bit_cnt == serd_pkg::LAST_DATA_BIT) begin
						if (shreg[7:4] == serd_pkg::SEL_PREFIX && shreg[3:1] == strap) begin
							next_sda_oe = 1'b1;
						end else begin
							next_state = serd_pkg::SERD_IDLE;
						end
					end else if (bit_cnt == serd_pkg::ACK_SLOT) begin
						next_bit_cnt = 4'h0;
						if (shreg[0]) begin
							// Read select: drive first data bit
							next_state = serd_pkg::SERD_READ;
							next_shreg = rd_byte;
							next_sda_oe = ~rd_byte[7];
						end else begin
							next_state = serd_pkg::SERD_ADDR_HI;
						end
					end
				end
				serd_pkg::SERD_ADDR_HI, serd_pkg::SERD_ADDR_LO: begin
					if (bit_cnt == serd_pkg::LAST_DATA_BIT) begin
						next_sda_oe = 1'b1;
						if (state == serd_pkg::SERD_ADDR_HI) begin
							next_addr = {shreg, addr[7:0]};
						end else begin
							next_addr = {addr[15:8], shreg};
						end
					end else if (bit_cnt == serd_pkg::ACK_SLOT) begin
						next_bit_cnt = 4'h0;
						next_state = (state == serd_pkg::SERD_ADDR_HI) ?
							serd_pkg::SERD_ADDR_LO : serd_pkg::SERD_WDATA;
					end
				end
				serd_pkg::SERD_WDATA: begin
					// Write data is not handled here; wait for restart or stop
					next_bit_cnt = 4'h0;
				end
				serd_pkg::SERD_READ: begin
					if (bit_cnt < serd_pkg::LAST_DATA_BIT) begin
						next_shreg = {shreg[6:0], 1'b0};
						next_sda_oe = ~shreg[6];
					end else if (bit_cnt == serd_pkg::LAST_DATA_BIT) begin
						// Byte out: advance counter, wrapping at array size
						next_addr = {{(serd_pkg::ADDR_W-serd_pkg::MEM_AW){1'b0}},
							mem_idx + 12'h001};
					end else begin
						// Host acked: next consecutive byte
						next_bit_cnt = 4'h0;
						next_shreg = rd_byte;
						next_sda_oe = ~rd_byte[7];
					end
				end
				default: begin
					next_state = serd_pkg::SERD_IDLE;
				end
			endcase
		end
		// Busy while any frame is open
		next_busy = (next_state != serd_pkg::SERD_IDLE);
	end

	// Protocol state registers
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= serd_pkg::SERD_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			addr <= 16'h0000;
			sda_oe <= 1'b0;
			skip_fall <= 1'b0;
			sda_o <= 1'b0;
			sda_oe_o <= 1'b0;
			busy_o <= 1'b0;
		end else begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			addr <= next_addr;
			sda_oe <= next_sda_oe;
			skip_fall <= next_skip_fall;
			sda_o <= 1'b0; // Open drain: only ever pulls low
			sda_oe_o <= next_sda_oe;
			busy_o <= next_busy;
		end
	end
endmodule

// file: hdl/serd_pkg.sv
// Package of constants and types for the serial EEPROM read engine
package serd_pkg;
	localparam int ADDR_W = 16;
	localparam int MEM_AW = 12;
	localparam int MEM_DEPTH = 4096;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [3:0] SEL_PREFIX = 4'hA;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	typedef enum logic [2:0] {
		SERD_IDLE = 3'b000,
		SERD_SEL = 3'b001,
		SERD_ADDR_HI = 3'b010,
		SERD_ADDR_LO = 3'b011,
		SERD_WDATA = 3'b100,
		SERD_READ = 3'b101
	} serd_state_t;
endpackage

// file: verification/serd_read_engine_checker.sv
// Checker of the read engine bus behaviour
`timescale 1ns/1ps
module serd_read_engine_checker (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// Bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	// Device outputs
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic busy_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	// Output discipline and framing
	low_only_a: assert property (sda_o == 1'h0) else $error("sda_o high");
	idle_rel_a: assert property (!busy_o |-> !sda_oe_o) else $error("idle drive");
	fall_only_a: assert property ($changed(sda_oe_o) |-> !$past(scl_i, 3)) else $error("oe edge");
	oe_hold_a: assert property ($rose(sda_oe_o) |-> sda_oe_o[*6]) else $error("oe short");
	start_busy_a: assert property ($past(scl_i) && scl_i && $fell(sda_i) |-> ##[1:6] busy_o) else $error("no busy");
	busy_cause_a: assert property ($rose(busy_o) |-> !sda_i && !$past(sda_i)) else $error("busy");
	stop_idle_a: assert property ($past(scl_i) && scl_i && $rose(sda_i) |-> ##[1:8] !busy_o) else $error("no idle");
	stop_rel_a: assert property ($past(scl_i) && scl_i && $rose(sda_i) |=> !sda_oe_o[*4]) else $error("oe stop");
	cover property ($rose(sda_oe_o));
	cover property ($fell(busy_o));
	cover property ($rose(busy_o));
endmodule
bind serd_read_engine serd_read_engine_checker chk (.*);

// file: verification/serd_host_model.sv
// Host controller model that clocks the two-wire bus
`timescale 1ns/1ps
module serd_host_model (
	// Clock and resolved data wire
	input wire logic sys_clk_i,
	input wire logic sda_i,
	// Bus clock and data drive, high means released
	output logic scl_o,
	output logic sda_drv_o
);
	initial begin
		scl_o = 1'h1;
		sda_drv_o = 1'h1;
	end
	// Wait a number of system clocks
	task automatic w(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask
	// One bit, data moves while the clock is low, sampled late in the high phase
	task automatic bitx(input logic b, output logic r);
		w(1);
		sda_drv_o <= b;
		w(3);
		scl_o <= 1'h1;
		w(4);
		r = sda_i;
		scl_o <= 1'h0;
	endtask
	// Data edge while the clock is high
	task automatic cond(input logic a, input logic b);
		w(1);
		sda_drv_o <= a;
		w(3);
		scl_o <= 1'h1;
		w(4);
		sda_drv_o <= b;
		w(4);
	endtask
	task automatic start;
		cond(1'h1, 1'h0);
		scl_o <= 1'h0;
	endtask
	task automatic stop;
		cond(1'h0, 1'h1);
	endtask
	// Byte MSB first, then the ninth slot
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
		bitx(a, k);
	endtask
endmodule

// file: verification/test_serd_read_engine.sv
// Testbench for the serial EEPROM read engine
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin fail_count++; \
	$display("[ERR] %s exp %h got %h", n, e, s); end end
module test_serd_read_engine;
	logic clk = 1'h0, rst_b = 1'h0, wp = 1'h0, k;
	logic [2:0] st = 3'h5;
	logic [7:0] q;
	int checks = 0, fail_count = 0;
	wire scl, hsda, oe, sda_o, busy;
	// Open-drain wire with pull-up
	wire sda = hsda & !oe;
	always #25 clk = !clk;
	serd_host_model u_host (.sys_clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_drv_o(hsda));
	serd_read_engine dut (.sys_clk_i(clk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_o(oe), .chip_select_strap_0_i(st[0]),
		.chip_select_strap_1_i(st[1]), .chip_select_strap_2_i(st[2]),
		.write_protect_input_i(wp), .busy_o(busy));
	// Start, select byte, ack level checked
	task automatic sel(input logic rw, input logic [2:0] c, input logic ea);
		u_host.start();
		u_host.xfer({4'hA, c, rw}, 1'h1, q, k);
		`CHK("ack", ea, k)
	endtask
	// One read byte: data, then whether the frame is still open
	task automatic rd(input logic a);
		u_host.xfer(8'hFF, a, q, k);
		`CHK("data", serd_pkg::ERASED_BYTE, q)
		`CHK("engaged", !a, busy)
	endtask
	// Dummy write to the top address, repeated start, read across the wrap
	task automatic t_random;
		sel(1'h0, st, 1'h0);
		u_host.xfer(8'h0F, 1'h1, q, k);
		`CHK("addr hi", 1'h0, k)
		u_host.xfer(8'hFF, 1'h1, q, k);
		`CHK("addr lo", 1'h0, k)
		sel(1'h1, st, 1'h0);
		rd(1'h0);
		rd(1'h1);
		u_host.stop();
		$display("random read done");
	endtask
	// Current read with protect high, stream, then nack
	task automatic t_seq;
		wp <= 1'h1;
		sel(1'h1, st, 1'h0);
		for (int i = 0; i < 3; i++) rd(1'h0);
		rd(1'h1);
		u_host.w(8);
		`CHK("busy", 1'h0, busy)
		`CHK("pull level", 1'h0, sda_o)
		u_host.stop();
		$display("sequential read done");
	endtask
	// Every strap code, only the matching one is acknowledged
	task automatic t_select;
		for (int c = 0; c < 8; c++) begin
			sel(1'h1, c[2:0], c[2:0] != st);
			if (k === 1'h0) rd(1'h1);
			u_host.stop();
		end
		$display("select codes done");
	endtask
	// Stop in mid byte drops the read
	task automatic t_abort;
		logic r;
		sel(1'h1, st, 1'h0);
		repeat (4) u_host.bitx(1'h1, r);
		u_host.stop();
		u_host.w(8);
		`CHK("abort", 1'h0, busy)
		$display("abort done");
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'h1;
		u_host.w(4);
		t_random();
		t_seq();
		t_select();
		t_abort();
		wrap_up();
	end
	// Watchdog against a hung bus
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		wrap_up();
	end
endmodule
